// file: irqcmp_pkg.sv
// Shared constants and types for the interrupt controller with comparator event logic
package irqcmp_pkg;

  localparam int DW = 8;

  // Special register addresses
  localparam logic [7:0] ADDR_CPC   = 8'h00;
  localparam logic [7:0] ADDR_EXT_PIN_EDGE_SELECT = 8'h01;
  localparam logic [7:0] ADDR_PRIMARY_IRQ_CTRL_0 = 8'h02;
  localparam logic [7:0] ADDR_PRIMARY_IRQ_CTRL_1 = 8'h03;
  localparam logic [7:0] ADDR_PRIMARY_IRQ_CTRL_2 = 8'h04;
  localparam logic [7:0] ADDR_MULTIFUNCTION_IRQ_CTRL_0  = 8'h05;
  localparam logic [7:0] ADDR_MULTIFUNCTION_IRQ_CTRL_1  = 8'h06;
  localparam logic [7:0] ADDR_MULTIFUNCTION_IRQ_CTRL_2  = 8'h07;

  // Implemented-bit masks, writable bits for MASK_CPC_W; the rest read as zero
  localparam logic [7:0] MASK_CPC   = 8'hF9;
  localparam logic [7:0] MASK_CPC_W = 8'hE9;
  localparam logic [7:0] MASK_EXT_PIN_EDGE_SELECT = 8'h0F;
  localparam logic [7:0] MASK_PRIMARY_IRQ_CTRL_0 = 8'h7F;
  localparam logic [7:0] MASK_FULL  = 8'hFF;
  localparam logic [7:0] MASK_HALF  = 8'h33;

  // Reset values
  localparam logic [7:0] RST_CPC  = 8'h81;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Comparator control bits
  localparam int CPC_PIN_SEL = 7;
  localparam int CPC_POWER   = 6;
  localparam int CPC_INVERT  = 5;
  localparam int CPC_RESULT  = 4;
  localparam int CPC_ROUTE   = 3;
  localparam int CPC_HYST    = 0;

  // Interrupt control bits
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_CMP_FLAG  = 5;
  localparam int FLAG_LSB      = 4;

  // Edge-select field positions and codes
  localparam int EDGE_W        = 2;
  localparam int PIN0_EDGE_LSB = 0;
  localparam int PIN1_EDGE_LSB = 2;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Vector indices, lowest index wins
  localparam int NUM_SRC = 9;
  localparam logic [3:0] VEC_NONE = 4'hF;

  typedef enum logic [1:0] {
    VST_IDLE    = 2'h0,
    VST_REQUEST = 2'h1,
    VST_SERVICE = 2'h3
  } irqcmp_vst_t;

  typedef struct packed {
    logic          wr;
    logic [7:0]    addr;
    logic [DW-1:0] wdata;
  } irqcmp_sfr_req_t;

endpackage

// file: irqcmp_ctrl.sv
// Interrupt request, enable and vectoring logic with comparator digital control
`timescale 1ns/1ns

// How it works
// - Comparator result change sets its flag; vectors when its enable is set.
// - Event comes from the polarity-adjusted result bit, not the output pin.
// - In sleep or idle with comparator on, a flag-setting change wakes the core.
// - A flag already high before sleep prevents later comparator wake-ups.
// - Comparator keeps working and making events during sleep and idle.
// - With comparator pins selected, port reads give zero if input, else latch.
// - Bit 7 hands both shared pins to comparator and drops pull-ups.
// - Bit 6 switches the comparator off at 0, on at 1.
// - Bit 5 selects raw or inverted comparator result.
// - Read-only bit 4 holds the polarity-adjusted comparator result.
// - Bit 3 at 0 drives result onto output pin; 1 keeps it internal.
// - Bit 0 enables hysteresis; bits 2 and 1 read zero.
// - A serviced interrupt suspends the program so the handler runs.
// - Requests come from external pins, timers, comparator, time bases, LVD, EEPROM, ADC.
// - Each source has a hardware-set flag and a software enable bit.
// - Pin 1 edge field in bits 3..2: off, rising, falling, both.
// - Pin 0 edge field in bits 1..0, same coding; bits 7..4 read zero.
// - Three primary and three multi-function registers pair flags with enables.
module irqcmp_ctrl #(
  parameter int NUM_PORT = 2
) (
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        resetn_in,
  // Special register access from the core
  input  wire irqcmp_pkg::irqcmp_sfr_req_t sfr_req_in,
  output logic [7:0]                       sfr_rdata_out,
  // Vectoring handshake with the core
  input  wire logic                        irq_ack_in,
  input  wire logic                        reti_in,
  input  wire logic                        sleep_in,
  output logic                             irq_req_out,
  output logic [3:0]                       irq_vec_out,
  output logic                             wake_out,
  // Event sources
  input  wire logic [1:0]                  ext_irq_pin_in,
  input  wire logic [5:0]                  tm_evt_in,
  input  wire logic [1:0]                  tb_evt_in,
  input  wire logic                        adc_evt_in,
  input  wire logic                        lvd_evt_in,
  input  wire logic                        eeprom_evt_in,
  // Analog comparator
  input  wire logic                        cmp_raw_in,
  output logic                             cmp_power_on_out,
  output logic                             cmp_hyst_on_out,
  output logic                             cmp_pin_sel_out,
  output logic                             cmp_out_pin_out,
  output logic                             cmp_out_pin_oe_out,
  // Shared port pins
  input  wire logic [NUM_PORT-1:0]         port_dir_in,
  input  wire logic [NUM_PORT-1:0]         port_latch_in,
  input  wire logic [NUM_PORT-1:0]         port_pin_in,
  output logic [NUM_PORT-1:0]              port_rd_out
);
  import irqcmp_pkg::*;

  logic [7:0]             comparator_control;
  logic [7:0]             ext_pin_edge_select;
  logic [7:0]             primary_irq_ctrl_0;
  logic [7:0]             primary_irq_ctrl_1;
  logic [7:0]             primary_irq_ctrl_2;
  logic [7:0]             multifunction_irq_ctrl_0;
  logic [7:0]             multifunction_irq_ctrl_1;
  logic [7:0]             multifunction_irq_ctrl_2;
  logic [1:0]             pin_prev;
  irqcmp_vst_t            vst;
  irqcmp_vst_t            next_vst;
  logic [3:0]             vec_held;

  // Register update: software write, then hardware clear, hardware set wins last
  function automatic logic [7:0] reg_next(input logic [7:0] cur, input logic hit,
                                          input logic [7:0] wdata, input logic [7:0] clr,
                                          input logic [7:0] set, input logic [7:0] mask);
    logic [7:0] v;
    v = hit ? wdata : cur;
    reg_next = ((v & ~clr) | set) & mask;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // Address decode
  wire wr_cpc   = sfr_req_in.wr && sfr_req_in.addr == ADDR_CPC;
  wire wr_ext_pin_edge_select = sfr_req_in.wr && sfr_req_in.addr == ADDR_EXT_PIN_EDGE_SELECT;
  wire wr_c0    = sfr_req_in.wr && sfr_req_in.addr == ADDR_PRIMARY_IRQ_CTRL_0;
  wire wr_c1    = sfr_req_in.wr && sfr_req_in.addr == ADDR_PRIMARY_IRQ_CTRL_1;
  wire wr_c2    = sfr_req_in.wr && sfr_req_in.addr == ADDR_PRIMARY_IRQ_CTRL_2;
  wire wr_m0    = sfr_req_in.wr && sfr_req_in.addr == ADDR_MULTIFUNCTION_IRQ_CTRL_0;
  wire wr_m1    = sfr_req_in.wr && sfr_req_in.addr == ADDR_MULTIFUNCTION_IRQ_CTRL_1;
  wire wr_m2    = sfr_req_in.wr && sfr_req_in.addr == ADDR_MULTIFUNCTION_IRQ_CTRL_2;

  // Comparator controls
  wire cmp_power_on   = comparator_control[CPC_POWER];
  wire cmp_invert_sel = comparator_control[CPC_INVERT];
  wire cmp_result_bit = comparator_control[CPC_RESULT];
  wire cmp_pin_sel    = comparator_control[CPC_PIN_SEL];
  wire cmp_out_route  = comparator_control[CPC_ROUTE];

  wire cmp_adjusted = cmp_raw_in ^ cmp_invert_sel;
  // result frozen while off, so switching off makes no event
  wire next_result = cmp_power_on ? cmp_adjusted : cmp_result_bit;
  wire cmp_evt = cmp_power_on && (next_result != cmp_result_bit);

  wire pin1_evt = edge_hit(ext_pin_edge_select[PIN1_EDGE_LSB +: EDGE_W], ext_irq_pin_in[1], pin_prev[1]);
  wire pin0_evt = edge_hit(ext_pin_edge_select[PIN0_EDGE_LSB +: EDGE_W], ext_irq_pin_in[0], pin_prev[0]);

  // multi-function flags follow any enabled sub-request
  wire mf0_set = |(multifunction_irq_ctrl_0[7:FLAG_LSB] & multifunction_irq_ctrl_0[FLAG_LSB-1:0]);
  wire mf1_set = |(multifunction_irq_ctrl_1[7:FLAG_LSB] & multifunction_irq_ctrl_1[FLAG_LSB-1:0]);
  wire mf2_set = |(multifunction_irq_ctrl_2[7:FLAG_LSB] & multifunction_irq_ctrl_2[FLAG_LSB-1:0]);

  // pending needs flag and enable; global enable checked in the sequencer
  wire [2:0] pend0 = primary_irq_ctrl_0[6:FLAG_LSB] & primary_irq_ctrl_0[3:1];
  wire [3:0] pend1 = primary_irq_ctrl_1[7:FLAG_LSB] & primary_irq_ctrl_1[FLAG_LSB-1:0];
  wire [1:0] pend2 = primary_irq_ctrl_2[5:FLAG_LSB] & primary_irq_ctrl_2[1:0];
  wire [NUM_SRC-1:0] pend = {pend2, pend1, pend0};
  wire global_irq_en = primary_irq_ctrl_0[BIT_GLOBAL_EN];

  logic [3:0] pick;
  always_comb begin
    pick = VEC_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 4'(i);
      end
    end
  end

  // Sequencer
  wire take_ack = (vst == VST_REQUEST) && irq_ack_in;
  wire take_ret = (vst == VST_SERVICE) && reti_in;

  always_comb begin
    next_vst = vst;
    case (vst)
      VST_IDLE: begin
        if (global_irq_en && pick != VEC_NONE) begin
          next_vst = VST_REQUEST;
        end
      end
      VST_REQUEST: begin
        if (irq_ack_in) begin
          next_vst = VST_SERVICE;
        end
      end
      VST_SERVICE: begin
        if (reti_in) begin
          next_vst = VST_IDLE;
        end
      end
      default: next_vst = VST_IDLE;
    endcase
  end

  // Acknowledge clears the serviced flag and masks further nesting
  logic [NUM_SRC-1:0] ack_oh;
  always_comb begin
    ack_oh = '0;
    if (take_ack && vec_held != VEC_NONE) begin
      ack_oh[vec_held] = 1'b1;
    end
  end

  wire [7:0] clr_c0 = {1'b0, ack_oh[2:0], 3'h0, take_ack};
  wire [7:0] clr_c1 = {ack_oh[6:3], 4'h0};
  wire [7:0] clr_c2 = {2'h0, ack_oh[8:7], 4'h0};

  wire [7:0] set_c0 = {1'b0, mf0_set, cmp_evt, pin0_evt, 3'h0, take_ret};
  wire [7:0] set_c1 = {tb_evt_in[0], adc_evt_in, mf2_set, mf1_set, 4'h0};
  wire [7:0] set_c2 = {2'h0, pin1_evt, tb_evt_in[1], 4'h0};
  wire [7:0] set_m0 = {2'h0, tm_evt_in[0], tm_evt_in[1], 4'h0};
  wire [7:0] set_m1 = {tm_evt_in[4], tm_evt_in[5], tm_evt_in[2], tm_evt_in[3], 4'h0};
  wire [7:0] set_m2 = {2'h0, eeprom_evt_in, lvd_evt_in, 4'h0};

  wire [7:0] cpc_wr_val = (sfr_req_in.wdata & MASK_CPC_W) | ({7'h0, next_result} << CPC_RESULT);
  wire [7:0] cpc_cur    = (comparator_control & ~(8'h01 << CPC_RESULT)) | ({7'h0, next_result} << CPC_RESULT);
  wire [7:0] next_cpc   = wr_cpc ? cpc_wr_val : cpc_cur;

  logic [7:0] rd_mux;
  always_comb begin
    case (sfr_req_in.addr)
      ADDR_CPC:   rd_mux = comparator_control & MASK_CPC;
      ADDR_EXT_PIN_EDGE_SELECT: rd_mux = ext_pin_edge_select;
      ADDR_PRIMARY_IRQ_CTRL_0: rd_mux = primary_irq_ctrl_0;
      ADDR_PRIMARY_IRQ_CTRL_1: rd_mux = primary_irq_ctrl_1;
      ADDR_PRIMARY_IRQ_CTRL_2: rd_mux = primary_irq_ctrl_2;
      ADDR_MULTIFUNCTION_IRQ_CTRL_0:  rd_mux = multifunction_irq_ctrl_0;
      ADDR_MULTIFUNCTION_IRQ_CTRL_1:  rd_mux = multifunction_irq_ctrl_1;
      ADDR_MULTIFUNCTION_IRQ_CTRL_2:  rd_mux = multifunction_irq_ctrl_2;
      default:    rd_mux = RST_ZERO;
    endcase
  end

  // port read substitution while pins belong to the comparator
  wire [NUM_PORT-1:0] port_rd_mux = cmp_pin_sel ? (port_latch_in & ~port_dir_in) : port_pin_in;

  // wake on a fresh comparator flag
  // flag already high means no wake
  wire next_wake = sleep_in && cmp_evt && !primary_irq_ctrl_0[BIT_CMP_FLAG];

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      comparator_control       <= RST_CPC;
      ext_pin_edge_select      <= RST_ZERO;
      primary_irq_ctrl_0       <= RST_ZERO;
      primary_irq_ctrl_1       <= RST_ZERO;
      primary_irq_ctrl_2       <= RST_ZERO;
      multifunction_irq_ctrl_0 <= RST_ZERO;
      multifunction_irq_ctrl_1 <= RST_ZERO;
      multifunction_irq_ctrl_2 <= RST_ZERO;
    end else begin
      comparator_control       <= next_cpc & MASK_CPC;
      ext_pin_edge_select      <= reg_next(ext_pin_edge_select, wr_ext_pin_edge_select, sfr_req_in.wdata, RST_ZERO, RST_ZERO,
                                           MASK_EXT_PIN_EDGE_SELECT);
      primary_irq_ctrl_0       <= reg_next(primary_irq_ctrl_0, wr_c0, sfr_req_in.wdata, clr_c0, set_c0, MASK_PRIMARY_IRQ_CTRL_0);
      primary_irq_ctrl_1       <= reg_next(primary_irq_ctrl_1, wr_c1, sfr_req_in.wdata, clr_c1, set_c1, MASK_FULL);
      primary_irq_ctrl_2       <= reg_next(primary_irq_ctrl_2, wr_c2, sfr_req_in.wdata, clr_c2, set_c2, MASK_HALF);
      multifunction_irq_ctrl_0 <= reg_next(multifunction_irq_ctrl_0, wr_m0, sfr_req_in.wdata, RST_ZERO, set_m0,
                                           MASK_HALF);
      multifunction_irq_ctrl_1 <= reg_next(multifunction_irq_ctrl_1, wr_m1, sfr_req_in.wdata, RST_ZERO, set_m1,
                                           MASK_FULL);
      multifunction_irq_ctrl_2 <= reg_next(multifunction_irq_ctrl_2, wr_m2, sfr_req_in.wdata, RST_ZERO, set_m2,
                                           MASK_HALF);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vst      <= VST_IDLE;
      vec_held <= VEC_NONE;
      pin_prev <= 2'h0;
    end else begin
      vst      <= next_vst;
      pin_prev <= ext_irq_pin_in;
      if (vst == VST_IDLE) begin
        vec_held <= pick;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sfr_rdata_out      <= RST_ZERO;
      irq_req_out        <= 1'b0;
      irq_vec_out        <= VEC_NONE;
      wake_out           <= 1'b0;
      port_rd_out        <= '0;
      cmp_out_pin_out    <= 1'b0;
      cmp_out_pin_oe_out <= 1'b0;
    end else begin
      sfr_rdata_out      <= rd_mux;
      // request holds until the core takes it
      irq_req_out        <= (next_vst == VST_REQUEST);
      irq_vec_out        <= (vst == VST_IDLE) ? pick : vec_held;
      wake_out           <= next_wake;
      port_rd_out        <= port_rd_mux;
      cmp_out_pin_out    <= next_result;
      cmp_out_pin_oe_out <= cmp_power_on && !cmp_out_route;
    end
  end

  // pin handover, power, hysteresis; straight from control flops
  assign cmp_power_on_out = comparator_control[CPC_POWER];
  assign cmp_hyst_on_out  = comparator_control[CPC_HYST];
  assign cmp_pin_sel_out  = comparator_control[CPC_PIN_SEL];

endmodule

// file: irqcmp_properties.sv
// Port-level assertions for the interrupt controller with comparator events
`timescale 1ns/1ns
module irqcmp_properties #(
  parameter int NUM_PORT = 2
) (
  // Clock and reset
  input wire logic                        core_clk_in,
  input wire logic                        resetn_in,
  // Register access and vector link
  input wire irqcmp_pkg::irqcmp_sfr_req_t sfr_req_in,
  input wire logic [7:0]                  sfr_rdata_out,
  input wire logic                        irq_ack_in,
  input wire logic                        irq_req_out,
  input wire logic [3:0]                  irq_vec_out,
  input wire logic                        sleep_in,
  input wire logic                        wake_out,
  // Comparator and shared port
  input wire logic                        cmp_power_on_out,
  input wire logic                        cmp_pin_sel_out,
  input wire logic                        cmp_out_pin_oe_out,
  input wire logic [NUM_PORT-1:0]         port_dir_in,
  input wire logic [NUM_PORT-1:0]         port_latch_in,
  input wire logic [NUM_PORT-1:0]         port_rd_out
);
  import irqcmp_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  cpc_gap_zero_a: assert property (sfr_req_in.addr == ADDR_CPC |=> sfr_rdata_out[2:1] == 2'h0)
    else $error("comparator control gap bits not zero");
  edge_top_zero_a: assert property (sfr_req_in.addr == ADDR_EXT_PIN_EDGE_SELECT |=> sfr_rdata_out[7:4] == 4'h0)
    else $error("edge select upper bits not zero");
  req_hold_a: assert property (irq_req_out && !irq_ack_in |=> irq_req_out && $stable(irq_vec_out))
    else $error("request dropped or vector moved before ack");
  ack_drop_a: assert property (irq_req_out && irq_ack_in |=> !irq_req_out)
    else $error("request still high after ack");
  vec_valid_a: assert property (irq_req_out |-> irq_vec_out < NUM_SRC)
    else $error("vector index out of range");
  wake_pulse_a: assert property (wake_out |=> !wake_out)
    else $error("wake longer than one cycle");
  wake_sleep_a: assert property (wake_out |-> $past(sleep_in))
    else $error("wake while not sleeping");
  port_zero_a: assert property (cmp_pin_sel_out && port_dir_in[0] |=> port_rd_out[0] == 1'b0)
    else $error("input pin read not zero");
  port_latch_a: assert property (cmp_pin_sel_out && !port_dir_in[0] |=> port_rd_out[0] == $past(port_latch_in[0]))
    else $error("output pin read not latch");
  oe_power_a: assert property (cmp_out_pin_oe_out |-> cmp_power_on_out || $past(cmp_power_on_out))
    else $error("output pin driven while off");

  cover property (wake_out);
  cover property (irq_req_out && irq_ack_in && irq_vec_out == 4'h1);
  cover property (cmp_pin_sel_out && port_dir_in[0]);
endmodule

bind irqcmp_ctrl irqcmp_properties #(.NUM_PORT(NUM_PORT)) u_props (
  .core_clk_in, .resetn_in, .sfr_req_in, .sfr_rdata_out, .irq_ack_in, .irq_req_out, .irq_vec_out,
  .sleep_in, .wake_out, .cmp_power_on_out, .cmp_pin_sel_out, .cmp_out_pin_oe_out,
  .port_dir_in, .port_latch_in, .port_rd_out);

// file: irqcmp_core_model.sv
// Core model that takes a vector and returns from the handler after a set delay
`timescale 1ns/1ns
module irqcmp_core_model (
  // Clock, reset and service delay
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic [3:0] delay_in,
  // Vector link
  input  wire logic       irq_req_in,
  output logic            ack_out,
  output logic            reti_out
);
  logic       busy;
  logic [3:0] cnt;
  wire        run = busy || irq_req_in;
  always @(negedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {busy, cnt, ack_out, reti_out} <= '0;
    end else begin
      ack_out  <= 1'b0;
      reti_out <= 1'b0;
      if (run) cnt <= cnt + 4'h1;
      if (run && cnt == delay_in) begin
        cnt      <= 4'h0;
        busy     <= !busy;
        ack_out  <= !busy;
        reti_out <= busy;
      end
    end
  end
endmodule

// file: irqcmp_ctrl_tb_top.sv
// Self-checking bench for the interrupt controller with comparator events
`timescale 1ns/1ns
module irqcmp_ctrl_tb_top;
  import irqcmp_pkg::*;
  logic            clk, rstn, ack, reti, sleep, raw, req_o, wake, pwr, hyst, sel, opin, oe, seen;
  logic            adce, lvde, eee;
  logic [1:0]      pin, tbe, dir, lat, ppin, rd;
  logic [5:0]      tme;
  logic [3:0]      vec;
  logic [7:0]      rdata;
  irqcmp_sfr_req_t req;
  int              num_errors, n_compared, p, c;

  irqcmp_ctrl dut (.core_clk_in(clk), .resetn_in(rstn), .sfr_req_in(req), .sfr_rdata_out(rdata),
    .irq_ack_in(ack), .reti_in(reti), .sleep_in(sleep), .irq_req_out(req_o), .irq_vec_out(vec),
    .wake_out(wake), .ext_irq_pin_in(pin), .tm_evt_in(tme), .tb_evt_in(tbe), .adc_evt_in(adce),
    .lvd_evt_in(lvde), .eeprom_evt_in(eee), .cmp_raw_in(raw), .cmp_power_on_out(pwr),
    .cmp_hyst_on_out(hyst), .cmp_pin_sel_out(sel), .cmp_out_pin_out(opin), .cmp_out_pin_oe_out(oe),
    .port_dir_in(dir), .port_latch_in(lat), .port_pin_in(ppin), .port_rd_out(rd));
  irqcmp_core_model core (.core_clk_in(clk), .resetn_in(rstn), .delay_in(4'h3), .irq_req_in(req_o),
    .ack_out(ack), .reti_out(reti));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp) fail(m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // An idle edge follows each write so back-to-back calls never re-raise the strobe in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, a, d};
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string m);
    req.addr = a;
    cyc(1);
    chk(rdata, exp, m);
  endtask
  // Waits for the request (s=0) or the wake pulse (s=1)
  task automatic wait_for(input int s, input int n);
    int i;
    for (i = 0; i < n && (s ? wake : req_o) !== 1'b1; i++) cyc(1);
    if ((s ? wake : req_o) !== 1'b1) begin
      fail("wait ran out");
      report_and_stop();
    end
  endtask

  initial begin
    {rstn, sleep, raw, seen} = '0;
    {pin, tbe, tme, adce, lvde, eee} = '0;
    dir = 2'h1;
    lat = 2'h3;
    ppin = 2'h3;
    req = '0;
    num_errors = 0;
    n_compared = 0;
    cyc(10);
    rstn = 1'b1;
    chk({sel, hyst, pwr, 1'b0, vec}, 8'hCF, "reset outputs");
    rdc(ADDR_CPC, 8'h81, "cpc reset");
    rdc(ADDR_EXT_PIN_EDGE_SELECT, 8'h00, "edge reset");
    rdc(ADDR_PRIMARY_IRQ_CTRL_0, 8'h00, "primary_irq_ctrl_0 reset");
    rdc(8'h20, 8'h00, "unmapped read");
    $display("reset test done");
    wr(ADDR_CPC, 8'hFF);
    cyc(1);
    rdc(ADDR_CPC, 8'hF9, "cpc all ones");
    chk({pwr, hyst, sel, oe}, 8'h0E, "cpc outputs, internal route");
    wr(ADDR_CPC, 8'h40);
    cyc(1);
    rdc(ADDR_CPC, 8'h40, "cpc plain on");
    chk({hyst, oe, opin}, 8'h02, "pin routed low");
    raw = 1'b1;
    cyc(2);
    rdc(ADDR_CPC, 8'h50, "result follows raw");
    chk(opin, 8'h01, "pin routed high");
    rdc(ADDR_PRIMARY_IRQ_CTRL_0, 8'h20, "flag on change");
    chk(req_o, 8'h00, "no vector without enables");
    wr(ADDR_PRIMARY_IRQ_CTRL_0, 8'h00);
    wr(ADDR_CPC, 8'h60);
    cyc(2);
    rdc(ADDR_PRIMARY_IRQ_CTRL_0, 8'h20, "flag on polarity flip");
    cyc(2);
    chk(rd, 8'h03, "port read as io");
    wr(ADDR_CPC, 8'hC0);
    cyc(2);
    chk({sel, rd}, 8'h06, "port read dir input");
    dir = 2'h2;
    cyc(2);
    chk(rd, 8'h01, "port read dir output");
    $display("comparator control test done");
    wr(ADDR_PRIMARY_IRQ_CTRL_0, 8'h05);
    raw = 1'b0;
    wait_for(0, 20);
    chk(vec, 8'h01, "comparator vector");
    cyc(15);
    rdc(ADDR_PRIMARY_IRQ_CTRL_0, 8'h05, "flag cleared, global back");
    tbe = 2'h1;
    cyc(1);
    tbe = 2'h0;
    cyc(1);
    rdc(ADDR_PRIMARY_IRQ_CTRL_1, 8'h80, "time base flag");
    {tme, adce, lvde, eee} = 9'h1FF;
    cyc(1);
    {tme, adce, lvde, eee} = 9'h000;
    rdc(ADDR_MULTIFUNCTION_IRQ_CTRL_0, 8'h30, "timer 0 flags");
    rdc(ADDR_MULTIFUNCTION_IRQ_CTRL_1, 8'hF0, "timer 1 and 2 flags");
    rdc(ADDR_MULTIFUNCTION_IRQ_CTRL_2, 8'h30, "memory and lvd flags");
    wr(ADDR_MULTIFUNCTION_IRQ_CTRL_2, 8'h31);
    cyc(1);
    rdc(ADDR_PRIMARY_IRQ_CTRL_1, 8'hE0, "adc flag and enabled mf2 flag");
    $display("vector test done");
    wr(ADDR_PRIMARY_IRQ_CTRL_0, 8'h00);
    sleep = 1'b1;
    raw = 1'b1;
    wait_for(1, 10);
    wr(ADDR_PRIMARY_IRQ_CTRL_0, 8'h20);
    raw = 1'b0;
    repeat (8) begin
      cyc(1);
      seen = seen | wake;
    end
    chk(seen, 8'h00, "wake suppressed by preset flag");
    wr(ADDR_CPC, 8'h80);
    raw = 1'b1;
    cyc(3);
    rdc(ADDR_CPC, 8'h80, "result frozen when off");
    sleep = 1'b0;
    $display("wake test done");
    wr(ADDR_EXT_PIN_EDGE_SELECT, 8'hFF);
    rdc(ADDR_EXT_PIN_EDGE_SELECT, 8'h0F, "edge upper bits");
    for (p = 0; p < 2; p++) begin
      for (c = 0; c < 4; c++) begin
        wr(ADDR_EXT_PIN_EDGE_SELECT, 8'(c << (2 * p)));
        wr(p ? ADDR_PRIMARY_IRQ_CTRL_2 : ADDR_PRIMARY_IRQ_CTRL_0, 8'h00);
        pin[p] = 1'b1;
        cyc(4);
        rdc(p ? ADDR_PRIMARY_IRQ_CTRL_2 : ADDR_PRIMARY_IRQ_CTRL_0, c[0] ? 8'(8'h10 << p) : 8'h00, "rising edge flag");
        wr(p ? ADDR_PRIMARY_IRQ_CTRL_2 : ADDR_PRIMARY_IRQ_CTRL_0, 8'h00);
        pin[p] = 1'b0;
        cyc(4);
        rdc(p ? ADDR_PRIMARY_IRQ_CTRL_2 : ADDR_PRIMARY_IRQ_CTRL_0, c[1] ? 8'(8'h10 << p) : 8'h00, "falling edge flag");
      end
    end
    $display("edge test done");
    report_and_stop();
  end
endmodule
